// ### call_return_pkg.sv
// package for the call/return sequencer: operations, steps, sizes, codes
// assumes a core that issues one command at a time and a memory that acks
`default_nettype none
package call_return_pkg;
  // ***************************************************
  // operations and micro-step actions
  // ***************************************************
  typedef enum logic [3:0] {
    OP_NCALL = 4'h0, OP_NRET  = 4'h1, OP_FCALL = 4'h2, OP_FRET = 4'h3,
    OP_PUSHALL = 4'h4, OP_POPALL = 4'h5, OP_PUSHLO = 4'h6, OP_PUSHFULL = 4'h7,
    OP_POPLO   = 4'h8, OP_POPFULL = 4'h9
  } op_t;
  typedef enum logic [3:0] {
    A_END = 4'h0, A_SKIP = 4'h1, A_PUSH = 4'h2, A_POP = 4'h3, A_SHPUSH = 4'h4,
    A_SHPOP = 4'h5, A_SHPEEK = 4'h6, A_ALIGN = 4'h7, A_CHK = 4'h8
  } act_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} state_t;

  // ***************************************************
  // sizes, offsets, codes, reset values
  // ***************************************************
  localparam logic [3:0]  SZ_WORD    = 4'h2;
  localparam logic [3:0]  SZ_DWORD   = 4'h4;
  localparam logic [3:0]  SZ_SHADOW  = 4'h8;
  localparam logic [31:0] SH_ALIGN   = 32'h0000_0007;
  localparam logic [31:0] SH_OFF_LIN = 32'h0000_0008;
  localparam logic [31:0] SH_OFF_CS  = 32'h0000_0010;
  localparam logic [3:0]  GPR_STEPS  = 4'h8;
  localparam int          GPR_SP     = 4;
  localparam logic [7:0]  FC_NEAR    = 8'h01;
  localparam logic [7:0]  FC_FAR     = 8'h02;
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  localparam logic [31:0] RST_FLAGS  = 32'h0000_0002;
  localparam logic [15:0] RST_SEL    = 16'h0000;
  // write-port selectors
  localparam logic [3:0]  WS_IP = 4'h8, WS_CS = 4'h9, WS_FL = 4'ha;
  localparam logic [3:0]  WS_SHP = 4'hb, WS_BASE = 4'hc;

  // ***************************************************
  // carriers
  // ***************************************************
  typedef struct packed {
    op_t         op;
    logic [15:0] targetSel;  // far call target selector
    logic [31:0] targetOff;  // call target offset
    logic [31:0] disp;       // near call displacement
    logic [15:0] relBytes;   // return byte-count operand
    logic [31:0] retBase;    // base of segment returned to
  } cmd_t;
  typedef struct packed {
    logic        write;
    logic        shadow;
    logic [31:0] addr;
    logic [3:0]  size;
    logic [63:0] wdata;
  } mem_req_t;
  typedef struct packed {
    logic [31:0] ip;
    logic [15:0] cs;
    logic [31:0] sp;
    logic [31:0] shadow_stack_ptr;
    logic [31:0] flags;
  } arch_t;
endpackage
`default_nettype wire

// ### call_return_sequencer.sv
// same-privilege call/return sequencer with shadow stack checks
// assumes memory holds request stable until memAck; core reads arch state
`default_nettype none
// Functional notes
// - near call pushes instr_ptr, then jumps to target offset
// - near call also shadow-pushes instr_ptr if enabled and displacement nonzero
// - near return pops instr_ptr and resumes caller
// - near return shadow pop must match popped address, else near-return fault
// - return byte count is added to stack_ptr after linkage pops
// - far call pushes code_seg_sel then instr_ptr
// - far call saves shadow pointer and rounds it up to 8 bytes
// - far call shadow-pushes selector, linear_ip, saved shadow pointer
// - far call then loads target selector and offset
// - far return pops instr_ptr then code_seg_sel
// - far return faults if shadow pointer is not 8-byte aligned
// - far return compares shadow entries at plus 8 and plus 16
// - passing far return pops saved shadow pointer, releases bytes, resumes
// - no registers or flags saved automatically on calls
// - push_all_gprs stores eight registers, original stack_ptr fifth
// - pop_all_gprs reloads all but skips stored stack_ptr
// - push_flags_low stores low word, push_flags_full whole flags_word
// - pop_flags_low loads low word, pop_flags_full whole flags_word
// - far-call shadow accesses are 64-bit, zero padded
module call_return_sequencer (
  input  wire logic                    clk,       // core clock
  input  wire logic                    srst,      // sync reset, high
  input  wire logic                    cmdValid,  // command offered
  input  wire call_return_pkg::cmd_t   cmd,       // command fields
  output logic                         cmdReady,  // idle, takes command
  input  wire logic                    shEnable,  // shadow stacking on
  input  wire logic                    wrEn,      // core register write
  input  wire logic [3:0]              wrSel,     // 0-7 gpr, 8+ others
  input  wire logic [31:0]             wrData,    // write value
  output logic                         memReq,    // memory access request
  output call_return_pkg::mem_req_t    memCmd,    // access fields
  input  wire logic                    memAck,    // access complete
  input  wire logic [63:0]             memRdata,  // read data
  output call_return_pkg::arch_t       arch,      // architectural state
  output logic [31:0]                  gprOut [8],// general registers
  output logic                         done,      // operation finished
  output logic                         fault,     // control-protection fault
  output logic [7:0]                   faultCode  // fault error code
);
  // ***************************************************
  // state
  // ***************************************************
  call_return_pkg::state_t state;
  call_return_pkg::cmd_t   c;
  call_return_pkg::act_t   act;
  logic [3:0]  step;
  logic [31:0] ip, shadow_stack_ptr, flags, csBase, tmpIp, startSp, savedSsp;
  logic [15:0] cs, tmpCs;
  logic [31:0] gpr [8];
  logic [31:0] val, off, cmpVal, sp;
  logic [3:0]  sz;

  // ***************************************************
  // step table: what each micro-step of each operation does
  // ***************************************************
  always_comb begin
    act    = call_return_pkg::A_END;
    val    = '0;
    off    = '0;
    cmpVal = '0;
    sz     = call_return_pkg::SZ_DWORD;
    case (c.op)
      call_return_pkg::OP_NCALL: begin
        val = ip; // only linkage is pushed
        if (step == 4'h0) act = call_return_pkg::A_PUSH;
        else if (step == 4'h1)
          act = (shEnable && c.disp != '0) ? call_return_pkg::A_SHPUSH
                                           : call_return_pkg::A_SKIP;
      end
      call_return_pkg::OP_NRET: begin
        cmpVal = tmpIp;
        if (step == 4'h0) act = call_return_pkg::A_POP;
        else if (step == 4'h1)
          act = shEnable ? call_return_pkg::A_SHPOP : call_return_pkg::A_SKIP;
      end
      call_return_pkg::OP_FCALL: begin
        case (step)
          4'h0: begin act = call_return_pkg::A_PUSH; val = {16'h0, cs}; end
          4'h1: act = shEnable ? call_return_pkg::A_ALIGN : call_return_pkg::A_SKIP;
          4'h2: begin act = call_return_pkg::A_SHPUSH; val = {16'h0, cs}; end
          4'h3: begin act = call_return_pkg::A_SHPUSH; val = csBase + ip; end
          4'h4: begin act = call_return_pkg::A_SHPUSH; val = savedSsp; end
          4'h5: begin act = call_return_pkg::A_PUSH; val = ip; end
          default: act = call_return_pkg::A_END;
        endcase
        if (!shEnable && (step == 4'h2 || step == 4'h3 || step == 4'h4))
          act = call_return_pkg::A_SKIP;
      end
      call_return_pkg::OP_FRET: begin
        case (step)
          4'h0: act = call_return_pkg::A_POP;
          4'h1: act = call_return_pkg::A_POP;
          4'h2: act = call_return_pkg::A_CHK;
          4'h3: begin act = call_return_pkg::A_SHPEEK; off = call_return_pkg::SH_OFF_LIN;
            cmpVal = c.retBase + tmpIp; end
          4'h4: begin act = call_return_pkg::A_SHPEEK; off = call_return_pkg::SH_OFF_CS;
            cmpVal = {16'h0, tmpCs}; end
          4'h5: act = call_return_pkg::A_SHPOP;
          default: act = call_return_pkg::A_END;
        endcase
        if (!shEnable && step >= 4'h2 && step <= 4'h5) act = call_return_pkg::A_SKIP;
      end
      call_return_pkg::OP_PUSHALL: begin
        // fifth slot is stack_ptr as it stood at the start
        val = (step == 4'(call_return_pkg::GPR_SP)) ? startSp : gpr[step[2:0]];
        if (step < call_return_pkg::GPR_STEPS) act = call_return_pkg::A_PUSH;
      end
      call_return_pkg::OP_POPALL:
        if (step < call_return_pkg::GPR_STEPS) act = call_return_pkg::A_POP;
      call_return_pkg::OP_PUSHLO, call_return_pkg::OP_PUSHFULL: begin
        val = flags;
        if (c.op == call_return_pkg::OP_PUSHLO) begin
          sz  = call_return_pkg::SZ_WORD;
          val = {16'h0, flags[15:0]};
        end
        if (step == 4'h0) act = call_return_pkg::A_PUSH;
      end
      call_return_pkg::OP_POPLO, call_return_pkg::OP_POPFULL: begin
        if (c.op == call_return_pkg::OP_POPLO) sz = call_return_pkg::SZ_WORD;
        if (step == 4'h0) act = call_return_pkg::A_POP;
      end
      default: act = call_return_pkg::A_END;
    endcase
    // every shadow access is a full zero-padded 64-bit slot
    if (act == call_return_pkg::A_SHPUSH || act == call_return_pkg::A_SHPOP ||
        act == call_return_pkg::A_SHPEEK)
      sz = call_return_pkg::SZ_SHADOW;
  end

  // ***************************************************
  // decode of the current step
  // ***************************************************
  wire running = (state == call_return_pkg::ST_RUN);
  wire isMem   = act inside {call_return_pkg::A_PUSH, call_return_pkg::A_POP,
                  call_return_pkg::A_SHPUSH, call_return_pkg::A_SHPOP,
                  call_return_pkg::A_SHPEEK};
  wire fire    = running && isMem && memAck;
  wire isRet   = (c.op == call_return_pkg::OP_NRET) || (c.op == call_return_pkg::OP_FRET);
  wire [31:0] pushAddr = sp - {28'h0, sz};
  wire [31:0] shPushAddr = shadow_stack_ptr - {28'h0, call_return_pkg::SZ_SHADOW};
  wire compares = (act == call_return_pkg::A_SHPEEK) ||
                  (act == call_return_pkg::A_SHPOP && c.op == call_return_pkg::OP_NRET);
  wire cmpBad  = fire && compares && (memRdata != {32'h0, cmpVal});
  wire chkBad  = running && act == call_return_pkg::A_CHK &&
                 (shadow_stack_ptr & call_return_pkg::SH_ALIGN) != '0;
  wire faultNow = cmpBad || chkBad;
  wire localGo = running && (act inside {call_return_pkg::A_SKIP,
                  call_return_pkg::A_ALIGN, call_return_pkg::A_CHK});
  wire stepGo  = (localGo && !chkBad) || (fire && !cmpBad);
  wire finish  = running && act == call_return_pkg::A_END;
  wire accept  = cmdValid && cmdReady;
  wire coreWr  = wrEn && !running; // core writes ignored mid-operation
  wire [2:0] popaIdx = 3'h7 - step[2:0]; // last pushed comes back first

  // memory request assembled from the step table; held until acked
  assign sp       = gpr[call_return_pkg::GPR_SP];
  assign cmdReady = (state == call_return_pkg::ST_IDLE);
  assign memReq   = running && isMem;
  assign memCmd.write  = (act == call_return_pkg::A_PUSH) || (act == call_return_pkg::A_SHPUSH);
  assign memCmd.shadow = (act != call_return_pkg::A_PUSH) && (act != call_return_pkg::A_POP);
  assign memCmd.size   = sz;
  assign memCmd.wdata  = {32'h0, val};
  assign memCmd.addr   = (act == call_return_pkg::A_PUSH)   ? pushAddr :
                         (act == call_return_pkg::A_POP)    ? sp :
                         (act == call_return_pkg::A_SHPUSH) ? shPushAddr : shadow_stack_ptr + off;
  assign arch = '{ip: ip, cs: cs, sp: sp, shadow_stack_ptr: shadow_stack_ptr, flags: flags};

  // ***************************************************
  // sequencing
  // ***************************************************
  // a fault leaves through idle with no commit, so the caller never resumes
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= call_return_pkg::ST_IDLE;
      step  <= 4'h0;
    end else if (accept) begin
      state <= call_return_pkg::ST_RUN;
      step  <= 4'h0;
    end else if (finish || faultNow) begin
      state <= call_return_pkg::ST_IDLE;
    end else if (stepGo) begin
      step <= step + 4'h1;
    end
  end

  // status pulses and fault code
  always_ff @(posedge clk) begin
    if (srst) begin
      done      <= 1'b0;
      fault     <= 1'b0;
      faultCode <= 8'h00;
    end else begin
      done  <= finish;
      fault <= faultNow;
      if (faultNow)
        faultCode <= (c.op == call_return_pkg::OP_NRET) ? call_return_pkg::FC_NEAR
                                                        : call_return_pkg::FC_FAR;
    end
  end

  // command capture and popped linkage
  always_ff @(posedge clk) begin
    if (srst) begin
      c       <= '0;
      tmpIp   <= call_return_pkg::RST_WORD;
      tmpCs   <= call_return_pkg::RST_SEL;
      startSp <= call_return_pkg::RST_WORD;
    end else if (accept) begin
      c       <= cmd;
      startSp <= sp;
    end else if (fire && act == call_return_pkg::A_POP && isRet) begin
      if (step == 4'h0) tmpIp <= memRdata[31:0];
      else tmpCs <= memRdata[15:0];
    end
  end

  // ***************************************************
  // architectural registers
  // ***************************************************
  // targets load only at the end, after every push has landed
  always_ff @(posedge clk) begin
    if (srst) begin
      ip <= call_return_pkg::RST_WORD;
      cs <= call_return_pkg::RST_SEL;
    end else if (coreWr && wrSel == call_return_pkg::WS_IP) begin
      ip <= wrData;
    end else if (coreWr && wrSel == call_return_pkg::WS_CS) begin
      cs <= wrData[15:0];
    end else if (finish) begin
      case (c.op)
        call_return_pkg::OP_NCALL: ip <= c.targetOff;
        call_return_pkg::OP_FCALL: begin ip <= c.targetOff; cs <= c.targetSel; end
        call_return_pkg::OP_NRET:  ip <= tmpIp;
        call_return_pkg::OP_FRET:  begin ip <= tmpIp; cs <= tmpCs; end
        default: ;
      endcase
    end
  end

  // segment base follows the core; the sequencer never changes it
  always_ff @(posedge clk) begin
    if (srst) csBase <= call_return_pkg::RST_WORD;
    else if (coreWr && wrSel == call_return_pkg::WS_BASE) csBase <= wrData;
  end

  // flags word
  always_ff @(posedge clk) begin
    if (srst) flags <= call_return_pkg::RST_FLAGS;
    else if (coreWr && wrSel == call_return_pkg::WS_FL) flags <= wrData;
    else if (fire && c.op == call_return_pkg::OP_POPLO) flags[15:0] <= memRdata[15:0];
    else if (fire && c.op == call_return_pkg::OP_POPFULL) flags <= memRdata[31:0];
  end

  // shadow pointer: a mismatched pop is not applied, so a fault leaves it intact
  always_ff @(posedge clk) begin
    if (srst) begin
      shadow_stack_ptr      <= call_return_pkg::RST_WORD;
      savedSsp <= call_return_pkg::RST_WORD;
    end else if (coreWr && wrSel == call_return_pkg::WS_SHP) begin
      shadow_stack_ptr <= wrData;
    end else if (running && act == call_return_pkg::A_ALIGN) begin
      savedSsp <= shadow_stack_ptr;
      shadow_stack_ptr <= (shadow_stack_ptr + call_return_pkg::SH_ALIGN) & ~call_return_pkg::SH_ALIGN;
    end else if (fire && act == call_return_pkg::A_SHPUSH) begin
      shadow_stack_ptr <= shPushAddr;
    end else if (fire && act == call_return_pkg::A_SHPOP && !cmpBad) begin
      shadow_stack_ptr <= (c.op == call_return_pkg::OP_FRET) ? memRdata[31:0]
             : shadow_stack_ptr + {28'h0, call_return_pkg::SZ_SHADOW};
    end
  end

  // general registers; entry four is the stack pointer
  for (genvar g = 0; g < 8; g++) begin : gen_gpr
    always_ff @(posedge clk) begin
      if (srst) begin
        gpr[g] <= call_return_pkg::RST_WORD;
      end else if (coreWr && wrSel == 4'(g)) begin
        gpr[g] <= wrData;
      end else if (g == call_return_pkg::GPR_SP) begin
        if (faultNow) gpr[g] <= startSp;
        else if (fire && act == call_return_pkg::A_PUSH) gpr[g] <= pushAddr;
        else if (fire && act == call_return_pkg::A_POP) gpr[g] <= sp + {28'h0, sz};
        else if (finish && isRet) gpr[g] <= sp + {16'h0, c.relBytes};
      end else if (fire && c.op == call_return_pkg::OP_POPALL && popaIdx == 3'(g)) begin
        gpr[g] <= memRdata[31:0];
      end
    end
    assign gprOut[g] = gpr[g];
  end

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence nearPopBad_s;
    fire && c.op == call_return_pkg::OP_NRET && act == call_return_pkg::A_SHPOP &&
    memRdata != {32'h0, tmpIp};
  endsequence
  sequence alignStep_s;
    running && act == call_return_pkg::A_ALIGN;
  endsequence
  ncall_push_a: assert property (memReq && c.op == call_return_pkg::OP_NCALL && step == 4'h0
    |-> memCmd.write && !memCmd.shadow && memCmd.addr == sp - 32'h4) else $error("near call push");
  ncall_noshadow_a: assert property (running && c.op == call_return_pkg::OP_NCALL &&
    step == 4'h1 && c.disp == '0 |-> !memReq) else $error("zero disp shadow push");
  near_mismatch_a: assert property (nearPopBad_s |=> fault && faultCode ==
    call_return_pkg::FC_NEAR && !running) else $error("near mismatch");
  ssp_align_a: assert property (alignStep_s |=> shadow_stack_ptr[2:0] == 3'h0 &&
    savedSsp == $past(shadow_stack_ptr)) else $error("shadow align");
  far_misalign_a: assert property (chkBad |=> fault && faultCode == call_return_pkg::FC_FAR)
    else $error("far misalign");
  fault_noresume_a: assert property (faultNow |=> $stable(ip) && $stable(cs) &&
    sp == $past(startSp)) else $error("fault resumed");
  shadow_width_a: assert property (memReq && memCmd.shadow |-> memCmd.size ==
    call_return_pkg::SZ_SHADOW && memCmd.wdata[63:32] == 32'h0) else $error("shadow width");
  pushall_sp_a: assert property (memReq && c.op == call_return_pkg::OP_PUSHALL && step == 4'h4
    |-> memCmd.wdata[31:0] == startSp) else $error("push_all_gprs sp slot");
  ret_release_a: assert property (finish && isRet |=> sp == $past(sp) +
    {16'h0, $past(c.relBytes)}) else $error("byte release");
  fcall_load_a: assert property (finish && c.op == call_return_pkg::OP_FCALL |=>
    ip == $past(c.targetOff) && cs == $past(c.targetSel)) else $error("far call load");
endmodule // call_return_sequencer
`default_nettype wire

// ### stack_mem_model.sv
// byte-addressed memory holding the procedure stack and the shadow stack
// assumes the sequencer holds memReq and memCmd steady until memAck
`default_nettype none
module stack_mem_model (
  input  wire logic                      clk,      // core clock
  input  wire logic                      memReq,   // access request
  input  wire call_return_pkg::mem_req_t memCmd,   // access fields
  input  wire logic [1:0]                ackDelay, // wait cycles per access
  output logic                           memAck,   // access complete
  output logic [63:0]                    memRdata  // read data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  bytes [logic [32:0]];
  logic [1:0]  waitCnt = 2'h0;
  logic [63:0] lastData = 64'h0;
  logic [63:0] rdNow;

  // ***************************************
  // backdoor, also used by the bench
  // ***************************************
  function automatic logic [63:0] peek(input logic sh, input logic [31:0] a, input int n);
    logic [63:0] v;
    v = 64'h0;
    for (int i = 0; i < n; i++) v[8*i +: 8] = bytes[{sh, a + 32'(i)}];
    return v;
  endfunction
  task automatic poke(input logic sh, input logic [31:0] a, input logic [63:0] d, input int n);
    for (int i = 0; i < n; i++) bytes[{sh, a + 32'(i)}] = d[8*i +: 8];
  endtask

  // ***************************************
  // access port
  // ***************************************
  // idle bus shows the inverse of the last value so stale data never matches
  assign rdNow = peek(memCmd.shadow, memCmd.addr, int'(memCmd.size));
  assign memAck = memReq && (waitCnt == ackDelay);
  assign memRdata = memAck ? rdNow : ~lastData;
  // store on the ack edge; count wait cycles otherwise
  always @(posedge clk) begin
    if (memReq && memAck) begin
      if (memCmd.write) poke(memCmd.shadow, memCmd.addr, memCmd.wdata, int'(memCmd.size));
      lastData <= memCmd.write ? memCmd.wdata : rdNow;
      waitCnt  <= 2'h0;
    end else if (memReq) begin
      waitCnt <= waitCnt + 2'h1;
    end
  end
endmodule // stack_mem_model
`default_nettype wire

// ### tb.sv
// self-checking bench for the call/return sequencer
// assumes the stack memory model answers every access of the sequencer
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        cmdValid = 1'b0;
  call_return_pkg::cmd_t cmd = '0;
  logic        shEnable = 1'b0;
  logic        wrEn = 1'b0;
  logic [3:0]  wrSel = 4'h0;
  logic [31:0] wrData = 32'h0;
  logic [1:0]  ackDelay = 2'h0;
  logic        cmdReady, memReq, memAck, done, fault;
  call_return_pkg::mem_req_t memCmd;
  logic [63:0] memRdata;
  call_return_pkg::arch_t arch;
  logic [31:0] gprOut [8];
  logic [7:0]  faultCode;
  int          failures = 0;
  int          cmpCount = 0;

  // 250 MHz core clock
  always #2 clk = ~clk;

  call_return_sequencer dut_u (.clk(clk), .srst(srst), .cmdValid(cmdValid), .cmd(cmd),
    .cmdReady(cmdReady), .shEnable(shEnable), .wrEn(wrEn), .wrSel(wrSel), .wrData(wrData),
    .memReq(memReq), .memCmd(memCmd), .memAck(memAck), .memRdata(memRdata), .arch(arch),
    .gprOut(gprOut), .done(done), .fault(fault), .faultCode(faultCode));
  stack_mem_model mem_u (.clk(clk), .memReq(memReq), .memCmd(memCmd), .ackDelay(ackDelay),
    .memAck(memAck), .memRdata(memRdata));

  // ***************************************
  // shared tasks
  // ***************************************
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (failures == 0 && cmpCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [3:0] s, input logic [31:0] d);
    @(negedge clk);
    wrEn = 1'b1;
    wrSel = s;
    wrData = d;
    @(negedge clk);
    wrEn = 1'b0;
  endtask
  task automatic setup(input logic [31:0] ip, cs, sp, shadow_stack_ptr);
    wr(call_return_pkg::WS_IP, ip);
    wr(call_return_pkg::WS_CS, cs);
    wr(4'h4, sp);
    wr(call_return_pkg::WS_SHP, shadow_stack_ptr);
  endtask
  // one command, then a bounded wait for its done or fault pulse
  task automatic run(input call_return_pkg::op_t op, input logic [31:0] off, dsp, base,
                     input logic [15:0] sel, rel, input logic ef, input logic [7:0] code);
    int n;
    @(negedge clk);
    cmd = '{op, sel, off, dsp, rel, base};
    cmdValid = 1'b1;
    @(negedge clk);
    cmdValid = 1'b0;
    n = 0;
    while (done !== 1'b1 && fault !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(done || fault, 1'b1);
    chk(fault, ef);
    if (ef) chk(faultCode, code);
  endtask

  // ***************************************
  // scenarios
  // ***************************************
  task automatic t_near();
    shEnable = 1'b1;
    setup(32'h100, 32'h0, 32'h1000, 32'h2000);
    run(call_return_pkg::OP_NCALL, 32'h500, 32'h400, 32'h0, 16'h0, 16'h0, 1'b0, 8'h00);
    chk(arch.ip, 32'h500);
    chk(mem_u.peek(1'b0, 32'hffc, 4), 32'h100);
    chk(arch.sp, 32'hffc);
    chk(mem_u.peek(1'b1, 32'h1ff8, 8), 32'h100);
    chk(arch.flags, call_return_pkg::RST_FLAGS);
    mem_u.poke(1'b1, 32'h1ff8, 64'h999, 8);
    run(call_return_pkg::OP_NRET, 32'h0, 32'h0, 32'h0, 16'h0, 16'h4, 1'b1,
        call_return_pkg::FC_NEAR);
    chk(arch.ip, 32'h500);
    chk(arch.sp, 32'hffc);
    mem_u.poke(1'b1, 32'h1ff8, 64'h100, 8);
    run(call_return_pkg::OP_NRET, 32'h0, 32'h0, 32'h0, 16'h0, 16'h4, 1'b0, 8'h00);
    chk(arch.ip, 32'h100);
    chk(arch.sp, 32'h1004);
    chk(arch.shadow_stack_ptr, 32'h2000);
    run(call_return_pkg::OP_NCALL, 32'h600, 32'h0, 32'h0, 16'h0, 16'h0, 1'b0, 8'h00);
    chk(arch.shadow_stack_ptr, 32'h2000);
  endtask
  task automatic t_far();
    ackDelay = 2'h2;
    setup(32'h200, 32'h10, 32'h1000, 32'h2004);
    wr(call_return_pkg::WS_BASE, 32'h10000);
    run(call_return_pkg::OP_FCALL, 32'h300, 32'h0, 32'h0, 16'h20, 16'h0, 1'b0, 8'h00);
    chk(mem_u.peek(1'b0, 32'hffc, 4), 32'h10);
    chk(mem_u.peek(1'b0, 32'hff8, 4), 32'h200);
    chk(mem_u.peek(1'b1, 32'h2000, 8), 64'h10);
    chk(mem_u.peek(1'b1, 32'h1ff8, 8), 64'h10200);
    chk(mem_u.peek(1'b1, 32'h1ff0, 8), 64'h2004);
    chk(arch.shadow_stack_ptr, 32'h1ff0);
    chk({arch.cs, arch.ip}, {16'h20, 32'h300});
    run(call_return_pkg::OP_FRET, 32'h0, 32'h0, 32'h20000, 16'h0, 16'h8, 1'b1,
        call_return_pkg::FC_FAR);
    chk({arch.ip, arch.sp}, {32'h300, 32'hff8});
    wr(call_return_pkg::WS_SHP, 32'h1ff4);
    run(call_return_pkg::OP_FRET, 32'h0, 32'h0, 32'h10000, 16'h0, 16'h8, 1'b1,
        call_return_pkg::FC_FAR);
    wr(call_return_pkg::WS_SHP, 32'h1ff0);
    // the callee leaves the selector alone, so the return finds it intact
    run(call_return_pkg::OP_FRET, 32'h0, 32'h0, 32'h10000, 16'h0, 16'h8, 1'b0, 8'h00);
    chk({arch.cs, arch.ip}, {16'h10, 32'h200});
    chk(arch.shadow_stack_ptr, 32'h2004);
    chk(arch.sp, 32'h1008);
  endtask
  task automatic t_gprs();
    ackDelay = 2'h1;
    for (int i = 0; i < 8; i++) wr(4'(i), (i == 4) ? 32'h1000 : 32'ha0 + 32'(i));
    run(call_return_pkg::OP_PUSHALL, 32'h0, 32'h0, 32'h0, 16'h0, 16'h0, 1'b0, 8'h00);
    for (int i = 0; i < 8; i++)
      chk(mem_u.peek(1'b0, 32'hffc - 32'(4*i), 4), (i == 4) ? 32'h1000 : 32'ha0 + 32'(i));
    chk(arch.sp, 32'hfe0);
    for (int i = 0; i < 8; i++) if (i != 4) wr(4'(i), 32'h0);
    mem_u.poke(1'b0, 32'hfec, 64'hdead, 4);
    run(call_return_pkg::OP_POPALL, 32'h0, 32'h0, 32'h0, 16'h0, 16'h0, 1'b0, 8'h00);
    for (int i = 0; i < 8; i++) chk(gprOut[i], (i == 4) ? 32'h1000 : 32'ha0 + 32'(i));
  endtask
  task automatic t_flags();
    wr(call_return_pkg::WS_FL, 32'h00abcd12);
    run(call_return_pkg::OP_PUSHLO, 32'h0, 32'h0, 32'h0, 16'h0, 16'h0, 1'b0, 8'h00);
    chk({mem_u.peek(1'b0, 32'hffe, 2), arch.sp}, {64'hcd12, 32'hffe});
    run(call_return_pkg::OP_PUSHFULL, 32'h0, 32'h0, 32'h0, 16'h0, 16'h0, 1'b0, 8'h00);
    chk({mem_u.peek(1'b0, 32'hffa, 4), arch.sp}, {64'habcd12, 32'hffa});
    mem_u.poke(1'b0, 32'hffa, 64'h11223344, 4);
    run(call_return_pkg::OP_POPFULL, 32'h0, 32'h0, 32'h0, 16'h0, 16'h0, 1'b0, 8'h00);
    chk({arch.flags, arch.sp}, {32'h11223344, 32'hffe});
    mem_u.poke(1'b0, 32'hffe, 64'h5566, 2);
    run(call_return_pkg::OP_POPLO, 32'h0, 32'h0, 32'h0, 16'h0, 16'h0, 1'b0, 8'h00);
    chk({arch.flags, arch.sp}, {32'h11225566, 32'h1000});
  endtask

  // ***************************************
  // main sequence and watchdog
  // ***************************************
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    chk({cmdReady, arch.flags, arch.sp}, {1'b1, call_return_pkg::RST_FLAGS, 32'h0});
    t_near();
    t_far();
    t_gprs();
    t_flags();
    results();
  end
  // far beyond the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end
endmodule // tb
`default_nettype wire
